// ---- hw/ppk_kernel.sv ----
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
module ppk_kernel
    import ppk_pkg::*;
#(
    parameter int PORTS = PPK_PORTS,
    parameter int WIDTH = PPK_WIDTH
)(
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire ppk_wb_req_s wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins, enable low while driving
    input wire logic [PORTS*WIDTH-1:0] pin_i,
    output logic [PORTS*WIDTH-1:0] pin_o,
    output logic [PORTS*WIDTH-1:0] pin_oe_n_o,
    // Peripheral side, three alternate output sources per line
    input wire logic [PORTS*WIDTH-1:0] alt_out1_i,
    input wire logic [PORTS*WIDTH-1:0] alt_out2_i,
    input wire logic [PORTS*WIDTH-1:0] alt_out3_i,
    input wire logic [PORTS*WIDTH-1:0] alt_dir_ctl_i,
    input wire logic [PORTS*WIDTH-1:0] alt_dir_i,
    output logic [PORTS*WIDTH-1:0] direct_peripheral_input_o,
    output logic [PORTS*WIDTH-1:0] input_latch_o,
    output logic [PPK_EXTINT_LINES-1:0] ext_irq_o
);

    localparam int LINES = PORTS * WIDTH;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Port index from address, or PORTS when outside all windows
    function automatic int port_of(input logic [31:0] adr);
        logic [31:0] rel;
        rel = adr - PPK_FIRST_BASE;
        if (adr < PPK_FIRST_BASE || adr > (PPK_LAST_BASE | 32'h000000FF))
            return PORTS;
        return int'(rel[15:8]);
    endfunction

    // Byte-lane merge of a 16-bit register, upper lanes ignored
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0])
            r[7:0] = wd[7:0];
        if (sel[1])
            r[15:8] = wd[15:8];
        return r;
    endfunction

    ppk_state_s s_q;
    ppk_state_s s_d;

    logic [LINES-1:0] out_flat;
    logic [LINES-1:0] dir_flat;
    logic [LINES-1:0] od_flat;
    logic [LINES-1:0] alt0_flat;
    logic [LINES-1:0] alt1_flat;

    // ****************************************************************
    // Flattened control bits per line
    // ****************************************************************
    always_comb
    begin
        for (int p = 0; p < PORTS; p++)
        begin
            out_flat[p*WIDTH +: WIDTH] = s_q.port[p].out;
            dir_flat[p*WIDTH +: WIDTH] = s_q.port[p].dir;
            od_flat[p*WIDTH +: WIDTH] = s_q.port[p].od;
            alt0_flat[p*WIDTH +: WIDTH] = s_q.port[p].alt0;
            alt1_flat[p*WIDTH +: WIDTH] = s_q.port[p].alt1;
        end
    end

    // ****************************************************************
    // Output multiplexer and driver control
    // ****************************************************************
    always_comb
    begin
        logic sel_val;
        logic drv_en;
        sel_val = 1'b0;
        drv_en = 1'b0;
        for (int i = 0; i < LINES; i++)
        begin
            unique case ({alt1_flat[i], alt0_flat[i]})
                2'b00: sel_val = out_flat[i];
                2'b01: sel_val = alt_out1_i[i];
                2'b10: sel_val = alt_out2_i[i];
                2'b11: sel_val = alt_out3_i[i];
            endcase
            // Peripheral owns direction only while an alternate is selected
            if (alt_dir_ctl_i[i] && (alt0_flat[i] || alt1_flat[i]))
                drv_en = alt_dir_i[i];
            else
                drv_en = dir_flat[i];
            // Open drain releases the line for a high level
            if (od_flat[i] && sel_val)
                drv_en = 1'b0;
            if (s_q.pwr_down)
                drv_en = 1'b0;
            pin_o[i] = sel_val;
            pin_oe_n_o[i] = ~drv_en;
        end
    end

    // ****************************************************************
    // Input paths
    // ****************************************************************
    // The peripheral copy is taken after the synchroniser, never its first stage
    assign direct_peripheral_input_o = s_q.sync2;
    assign input_latch_o = s_q.latch;
    // Interrupt lines are the first 24 synchronised lines, gated per line
    assign ext_irq_o = s_q.sync2[PPK_EXTINT_LINES-1:0] & s_q.extint_en;

    assign wb_dat_o = s_q.rdata;
    assign wb_ack_o = s_q.ack;

    // ****************************************************************
    // Next state: synchroniser, latch and register bus
    // ****************************************************************
    always_comb
    begin
        int p;
        logic [7:0] ofs;
        logic [15:0] rd16;
        logic hit;
        logic req;
        p = 0;
        ofs = 8'h00;
        rd16 = 16'h0000;
        hit = 1'b0;
        req = 1'b0;
        s_d = s_q;
        // Sampled every edge regardless of direction
        s_d.sync1 = pin_i;
        s_d.sync2 = s_q.sync1;
        s_d.latch = s_q.sync2;
        s_d.ack = 1'b0;
        // Ack for one cycle; the gap lets the master drop strobes
        req = wb_req_i.cyc && wb_req_i.stb && !s_q.ack;
        if (req)
        begin
            p = port_of(wb_req_i.adr);
            ofs = wb_req_i.adr[7:0];
            s_d.ack = 1'b1;
            s_d.rdata = 32'h00000000;
            if (p < PORTS)
            begin
                hit = 1'b1;
                unique case (ofs)
                    PPK_OFS_OUT: rd16 = s_q.port[p].out;
                    PPK_OFS_IN: rd16 = s_q.latch[p*WIDTH +: WIDTH];
                    PPK_OFS_DIR: rd16 = s_q.port[p].dir;
                    PPK_OFS_OD: rd16 = s_q.port[p].od;
                    PPK_OFS_ALT0: rd16 = s_q.port[p].alt0;
                    PPK_OFS_ALT1: rd16 = s_q.port[p].alt1;
                    PPK_OFS_EXTINT:
                        rd16 = (p == 0) ? s_q.extint_en[15:0] :
                               (p == 1) ? {8'h00, s_q.extint_en[23:16]} : 16'h0000;
                    PPK_OFS_PWR: rd16 = {15'h0000, s_q.pwr_down};
                    default: rd16 = 16'h0000;
                endcase
                s_d.rdata = {16'h0000, rd16};
            end
            if (hit && wb_req_i.we)
            begin
                unique case (ofs)
                    PPK_OFS_OUT:
                        s_d.port[p].out = merge16(s_q.port[p].out, wb_req_i.dat, wb_req_i.sel);
                    PPK_OFS_DIR:
                        s_d.port[p].dir = merge16(s_q.port[p].dir, wb_req_i.dat, wb_req_i.sel);
                    PPK_OFS_OD:
                        s_d.port[p].od = merge16(s_q.port[p].od, wb_req_i.dat, wb_req_i.sel);
                    PPK_OFS_ALT0:
                        s_d.port[p].alt0 = merge16(s_q.port[p].alt0, wb_req_i.dat,
                                                   wb_req_i.sel);
                    PPK_OFS_ALT1:
                        s_d.port[p].alt1 = merge16(s_q.port[p].alt1, wb_req_i.dat,
                                                   wb_req_i.sel);
                    PPK_OFS_EXTINT:
                    begin
                        if (p == 0)
                            s_d.extint_en[15:0] = merge16(s_q.extint_en[15:0],
                                                          wb_req_i.dat, wb_req_i.sel);
                        else if (p == 1 && wb_req_i.sel[0])
                            s_d.extint_en[23:16] = wb_req_i.dat[7:0];
                    end
                    PPK_OFS_PWR:
                        if (p == 0 && wb_req_i.sel[0])
                            s_d.pwr_down = wb_req_i.dat[0];
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
            for (int k = 0; k < PORTS; k++)
            begin
                s_q.port[k].out <= PPK_RST_OUT;
                s_q.port[k].dir <= PPK_RST_DIR;
                s_q.port[k].od <= PPK_RST_OD;
                s_q.port[k].alt0 <= PPK_RST_ALT;
                s_q.port[k].alt1 <= PPK_RST_ALT;
            end
            s_q.extint_en <= PPK_RST_EXTINT;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule

// ---- hw/ppk_pkg.sv ----
package ppk_pkg;

    // ****************************************************************
    // Register map, byte offsets within one port's 256-byte window
    // ****************************************************************
    localparam logic [7:0] PPK_OFS_OUT = 8'h10;
    localparam logic [7:0] PPK_OFS_IN = 8'h14;
    localparam logic [7:0] PPK_OFS_DIR = 8'h18;
    localparam logic [7:0] PPK_OFS_OD = 8'h1C;
    localparam logic [7:0] PPK_OFS_ALT0 = 8'h44;
    localparam logic [7:0] PPK_OFS_ALT1 = 8'h48;
    localparam logic [7:0] PPK_OFS_EXTINT = 8'h80;
    localparam logic [7:0] PPK_OFS_PWR = 8'h84;

    // ****************************************************************
    // Port windows and geometry
    // ****************************************************************
    localparam logic [31:0] PPK_FIRST_BASE = 32'hF0002800;
    localparam logic [31:0] PPK_LAST_BASE = 32'hF0002D00;
    localparam int PPK_PORTS = 6;
    localparam int PPK_WIDTH = 16;
    localparam int PPK_LINES = PPK_PORTS * PPK_WIDTH;
    localparam int PPK_EXTINT_LINES = 24;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] PPK_RST_OUT = 16'h0000;
    localparam logic [15:0] PPK_RST_DIR = 16'h0000;
    localparam logic [15:0] PPK_RST_OD = 16'h0000;
    localparam logic [15:0] PPK_RST_ALT = 16'h0000;
    localparam logic [23:0] PPK_RST_EXTINT = 24'h000000;

    // Control registers of one port
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] dir;
        logic [15:0] od;
        logic [15:0] alt0;
        logic [15:0] alt1;
    } ppk_port_s;

    // Whole kernel state
    typedef struct packed {
        ppk_port_s [PPK_PORTS-1:0] port;
        logic [PPK_LINES-1:0] sync1;
        logic [PPK_LINES-1:0] sync2;
        logic [PPK_LINES-1:0] latch;
        logic [23:0] extint_en;
        logic pwr_down;
        logic ack;
        logic [31:0] rdata;
    } ppk_state_s;

    // Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } ppk_wb_req_s;

endpackage

// ---- dv/ppk_pins_model.sv ----
`timescale 1ns/1ns
module ppk_pins_model
    import ppk_pkg::*;
(
    input wire logic [PPK_LINES-1:0] drv_i,
    input wire logic [PPK_LINES-1:0] oe_n_i,
    input wire logic [PPK_LINES-1:0] ext_en_i,
    input wire logic [PPK_LINES-1:0] ext_val_i,
    output logic [PPK_LINES-1:0] level_o
);
    // Kernel drive wins; a released line follows the board, else its pull-up
    assign level_o = (~oe_n_i & drv_i) | (oe_n_i & (~ext_en_i | ext_val_i));
endmodule

// ---- dv/ppk_kernel_chk.sv ----
`timescale 1ns/1ns
module ppk_kernel_chk
    import ppk_pkg::*;
#(
    parameter int PORTS = PPK_PORTS,
    parameter int WIDTH = PPK_WIDTH
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ppk_wb_req_s wb_req_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [PORTS*WIDTH-1:0] pin_i,
    input wire logic [PORTS*WIDTH-1:0] pin_oe_n_o,
    input wire logic [PORTS*WIDTH-1:0] direct_peripheral_input_o,
    input wire logic [PORTS*WIDTH-1:0] input_latch_o,
    input wire logic [PPK_EXTINT_LINES-1:0] ext_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Cycles since reset, so sync checks skip the refill of the flops
    logic [1:0] up_q;
    logic [1:0] up_d;
    always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
    always_ff @(posedge clk_i) up_q <= rst_i ? 2'h0 : up_d;
    // Bus request taken, answer pulse, power down command
    sequence s_take;
        wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_pwr;
        s_take ##0 wb_req_i.we && wb_req_i.sel[0] && wb_req_i.dat[0]
            && wb_req_i.adr == (PPK_FIRST_BASE | 32'(PPK_OFS_PWR));
    endsequence
    a_ack_pulse: assert property (s_take |=> s_pulse)
        else $error("ack not one pulse");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_req_i.stb))
        else $error("ack without request");
    a_hi_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_reset_off: assert property ($past(rst_i) |-> &pin_oe_n_o)
        else $error("driver on after reset");
    a_pwr_off: assert property (s_pwr |=> &pin_oe_n_o [*2])
        else $error("driver on in power down");
    a_sync_two: assert property (up_q == 2'h3 |->
        direct_peripheral_input_o == $past(pin_i, 2)) else $error("direct input late");
    a_latch_next: assert property (up_q == 2'h3 |->
        input_latch_o == $past(direct_peripheral_input_o)) else $error("latch stale");
    a_irq_level: assert property (|ext_irq_o |->
        (ext_irq_o & ~direct_peripheral_input_o[23:0]) == 24'h0)
        else $error("irq without level");
endmodule
bind ppk_kernel ppk_kernel_chk #(.PORTS(PORTS), .WIDTH(WIDTH)) ppk_kernel_chk_inst (
    .clk_i, .rst_i, .wb_req_i, .wb_dat_o, .wb_ack_o, .pin_i, .pin_oe_n_o,
    .direct_peripheral_input_o, .input_latch_o, .ext_irq_o
);

// ---- dv/ppk_kernel_bench.sv ----
`timescale 1ns/1ns
module ppk_kernel_bench
    import ppk_pkg::*;
();
    localparam logic [7:0] OFS [5] = '{PPK_OFS_OUT, PPK_OFS_DIR, PPK_OFS_OD, PPK_OFS_ALT0,
        PPK_OFS_ALT1};
    // Shadow copies of the registers, used to predict pins
    logic [15:0] sh [6][5];
    logic [23:0] irq_en = 24'h000000;
    logic pd = 1'b0;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    ppk_wb_req_s wb_req_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [23:0] ext_irq_o;
    logic [95:0] pin_i, pin_o, pin_oe_n_o, direct_peripheral_input_o, input_latch_o;
    logic [95:0] alt_out1_i = '0, alt_out2_i = '0, alt_out3_i = '0, alt_dir_ctl_i = '0;
    logic [95:0] alt_dir_i = '0, ext_en = '0, ext_val = '0;
    int n_mismatch = 0;
    int checks = 0;
    // Free-running clock, 20 ns period
    initial forever #10 clk_i = ~clk_i;
    ppk_kernel ppk_kernel_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(wb_req_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .pin_i(pin_i),
        .pin_o(pin_o),
        .pin_oe_n_o(pin_oe_n_o),
        .alt_out1_i(alt_out1_i),
        .alt_out2_i(alt_out2_i),
        .alt_out3_i(alt_out3_i),
        .alt_dir_ctl_i(alt_dir_ctl_i),
        .alt_dir_i(alt_dir_i),
        .direct_peripheral_input_o(direct_peripheral_input_o),
        .input_latch_o(input_latch_o),
        .ext_irq_o(ext_irq_o)
    );
    ppk_pins_model ppk_pins_model_inst (.drv_i(pin_o), .oe_n_i(pin_oe_n_o),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_i));
    function automatic logic [95:0] rnd();
        return {$urandom, $urandom, $urandom};
    endfunction
    function automatic logic [31:0] adr(input int p, input logic [7:0] o);
        return PPK_FIRST_BASE + 32'(p) * 32'h100 + 32'(o);
    endfunction
    task automatic chk(input string s, input logic [95:0] e, input logic [95:0] g);
        checks++;
        n_mismatch += int'(g !== e);
        if (g !== e)
            $display("unexpected %s: expected %h, seen %h", s, e, g);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Classic cycle, called at a rising edge; request held until ack is sampled high
    task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        wb_req_i <= '{1'b1, 1'b1, w, 4'hF, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_req_i <= '0;
        // One idle edge so the next request is seen as a new cycle
        @(posedge clk_i);
    endtask
    task automatic wr(input int p, input int k, input logic [15:0] v);
        logic [31:0] r;
        sh[p][k] = v;
        wb(adr(p, OFS[k]), 1'b1, {16'h0000, v}, r);
        wb(adr(p, OFS[k]), 1'b0, 32'h0, r);
        chk("readback", {80'h0, v}, {64'h0, r});
    endtask
    // Predict drive and levels from the shadows; bus reads follow the wait
    task automatic chk_all();
        logic [95:0] en, v, lv;
        logic [31:0] r;
        logic [1:0] s;
        for (int i = 0; i < 96; i++)
        begin
            s = {sh[i/16][4][i%16], sh[i/16][3][i%16]};
            v[i] = s == 2'h0 ? sh[i/16][0][i%16] : s == 2'h1 ? alt_out1_i[i]
                : s == 2'h2 ? alt_out2_i[i] : alt_out3_i[i];
            en[i] = (s != 2'h0 && alt_dir_ctl_i[i]) ? alt_dir_i[i] : sh[i/16][1][i%16];
            en[i] = en[i] && !pd && !(sh[i/16][2][i%16] && v[i]);
        end
        lv = (en & v) | (~en & (~ext_en | ext_val));
        chk("oe", ~en, pin_oe_n_o);
        chk("pin", en & v, en & pin_o);
        repeat (4) @(posedge clk_i);
        chk("direct", lv, direct_peripheral_input_o);
        chk("latch", lv, input_latch_o);
        chk("irq", {72'h0, lv[23:0] & irq_en}, {72'h0, ext_irq_o});
        for (int p = 0; p < 6; p++)
        begin
            wb(adr(p, PPK_OFS_IN), 1'b0, 32'h0, r);
            chk("in", {80'h0, lv[p*16 +: 16]}, {64'h0, r});
        end
    endtask
    // Reset, corner rounds, random rounds, then unmapped places
    initial
    begin
        logic [31:0] r;
        void'($urandom(49627));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int p = 0; p < 6; p++)
            for (int k = 0; k < 5; k++)
            begin
                sh[p][k] = 16'h0000;
                wb(adr(p, OFS[k]), 1'b0, 32'h0, r);
                chk("reset", 96'h0, {64'h0, r});
            end
        chk_all();
        for (int i = 0; i < 20; i++)
        begin
            {alt_out1_i, alt_out2_i, alt_out3_i, alt_dir_ctl_i, alt_dir_i, ext_en, ext_val}
                <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            irq_en = 24'($urandom);
            wb(adr(0, PPK_OFS_EXTINT), 1'b1, {16'h0000, irq_en[15:0]}, r);
            wb(adr(1, PPK_OFS_EXTINT), 1'b1, {24'h000000, irq_en[23:16]}, r);
            for (int p = 0; p < 6; p++)
                for (int k = 0; k < 5; k++)
                    wr(p, k, i == 0 ? (k < 2 ? 16'hFFFF : 16'h0000)
                        : (i < 3 && k > 1) ? 16'h0000 : 16'($urandom));
            chk_all();
            pd = i == 3;
            wb(adr(0, PPK_OFS_PWR), 1'b1, {31'h0, pd}, r);
            if (pd)
                chk_all();
        end
        wb(adr(6, PPK_OFS_OUT), 1'b1, 32'h0000FFFF, r);
        wb(adr(6, PPK_OFS_OUT), 1'b0, 32'h0, r);
        chk("unmapped", 96'h0, {64'h0, r});
        wb(adr(2, 8'h20), 1'b0, 32'h0, r);
        chk("unmapped", 96'h0, {64'h0, r});
        chk_all();
        tally_and_finish();
    end
    // Watchdog against a hung handshake
    initial
    begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
